/* alarm_pkg.sv */
// constants, types and state layouts for the dual alarm monitor
package alarm_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [5:0] ADDR_LIMIT1 = 6'h20;
  localparam logic [5:0] ADDR_LIMIT2 = 6'h22;
  localparam logic [5:0] ADDR_SAMPLES1 = 6'h24;
  localparam logic [5:0] ADDR_SAMPLES2 = 6'h26;
  localparam logic [5:0] ADDR_CONTROL = 6'h28;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int LIM_ABOVE_BIT = 15;
  localparam int LIM_DATA_MSB = 13;
  localparam int LIM_W = 14;
  localparam int SMP_COUNT_MSB = 7;
  localparam int CTL_SLOPE2_BIT = 15;
  localparam int CTL_SRC2_LSB = 12;
  localparam int CTL_SLOPE1_BIT = 11;
  localparam int CTL_SRC1_LSB = 8;
  localparam int CTL_PIN_EN_BIT = 2;
  localparam int CTL_PIN_POL_BIT = 1;
  localparam int CTL_PIN_SEL_BIT = 0;

  // writable bits; the rest read as zero
  localparam logic [15:0] LIMIT_MASK = 16'hBFFF;
  localparam logic [15:0] SAMPLES_MASK = 16'h00FF;
  localparam logic [15:0] CONTROL_MASK = 16'hFF07;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [15:0] SAMPLES_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] FETCH_LAST = 3'h4;

  // watched output selection
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_SUPPLY = 3'h1,
    SRC_X_ACCEL = 3'h2,
    SRC_Y_ACCEL = 3'h3,
    SRC_AUX_ADC = 3'h4,
    SRC_TEMP = 3'h5,
    SRC_X_TILT = 3'h6,
    SRC_Y_TILT = 3'h7
  } source_t;

  // register decode result
  typedef enum logic [2:0] {
    W_LIMIT1 = 3'h0,
    W_LIMIT2 = 3'h1,
    W_SAMPLES1 = 3'h2,
    W_SAMPLES2 = 3'h3,
    W_CONTROL = 3'h4,
    W_NONE = 3'h7
  } word_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_RUN = 2'h1
  } state_t;

  typedef logic [LIM_W-1:0] datum_t;

  // instantaneous output data set
  typedef struct packed {
    datum_t supply;
    datum_t x_accel;
    datum_t y_accel;
    datum_t aux_adc;
    datum_t temp;
    datum_t x_tilt;
    datum_t y_tilt_output;
  } sample_set_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } pin_pair_t;

  // one alarm monitor
  typedef struct packed {
    datum_t ref_val;
    logic [7:0] count;
    logic primed;
    logic active;
  } alarm_t;

  typedef struct packed {
    state_t state;
    logic [2:0] idx;
    logic [1:0][15:0] limit;
    logic [1:0][15:0] samples;
    logic [15:0] control;
    alarm_t [1:0] al;
    reg_rsp_t rsp;
    pin_pair_t pins;
  } monitor_state_t;

  typedef struct packed {
    logic [3:0][15:0] words;
    logic [15:0] rd_data;
  } nv_state_t;

endpackage

/* nv_word_store.sv */
// nonvolatile store for the alarm limit and sample-count words
`timescale 1ns/100ps
`default_nettype none
module nv_word_store (
  input wire logic core_clk,
  input wire logic erase,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [15:0] rd_data
);
  import alarm_pkg::*;

  nv_state_t s_reg; // stored words and read register
  nv_state_t s_next; // next value

  // --------------------------------------------------------------
  // write and registered read; only erase clears, never rst
  // --------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rd_data = s_reg.words[rd_idx];
    if (wr_en) begin
      s_next.words[wr_idx] = wr_data;
    end
  end

  // erase stands for first power-up
  always_ff @(posedge core_clk) begin
    if (erase) begin
      s_reg.words <= {4{WORD_RESET}};
      s_reg.rd_data <= WORD_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd_data;

endmodule // nv_word_store
`default_nettype wire

/* dual_alarm_monitor.sv */
// two alarm monitors with shared control and a shared alarm pin
`timescale 1ns/100ps
`default_nettype none
module dual_alarm_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic nv_erase,
  input wire logic sample_strobe,
  input wire alarm_pkg::sample_set_t samples_in,
  input wire alarm_pkg::reg_req_t reg_req,
  output logic reg_ready,
  output alarm_pkg::reg_rsp_t reg_rsp,
  input wire logic [1:0] misc_claim,
  input wire logic [1:0] misc_drive,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic io_line_zero_out,
  output logic io_line_zero_oe,
  output logic io_line_one_out,
  output logic io_line_one_oe,
  output logic alarm1_active,
  output logic alarm2_active
);
  import alarm_pkg::*;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // address to register word
  function automatic word_t decode(input logic [5:0] a);
    case (a)
      ADDR_LIMIT1: decode = W_LIMIT1;
      ADDR_LIMIT2: decode = W_LIMIT2;
      ADDR_SAMPLES1: decode = W_SAMPLES1;
      ADDR_SAMPLES2: decode = W_SAMPLES2;
      ADDR_CONTROL: decode = W_CONTROL;
      default: decode = W_NONE;
    endcase
  endfunction

  // source field of one alarm
  function automatic source_t ctl_src(input logic [15:0] c, input logic k);
    ctl_src = source_t'(k ? c[CTL_SRC2_LSB +: 3] : c[CTL_SRC1_LSB +: 3]);
  endfunction

  // slope enable of one alarm
  function automatic logic ctl_slope(input logic [15:0] c, input logic k);
    ctl_slope = k ? c[CTL_SLOPE2_BIT] : c[CTL_SLOPE1_BIT];
  endfunction

  // raw value of the watched output
  function automatic datum_t pick(input sample_set_t s, input source_t src);
    case (src)
      SRC_SUPPLY: pick = s.supply;
      SRC_X_ACCEL: pick = s.x_accel;
      SRC_Y_ACCEL: pick = s.y_accel;
      SRC_AUX_ADC: pick = s.aux_adc;
      SRC_TEMP: pick = s.temp;
      SRC_X_TILT: pick = s.x_tilt;
      SRC_Y_TILT: pick = s.y_tilt_output;
      default: pick = '0;
    endcase
  endfunction

  // acceleration and tilt are two's complement
  function automatic logic is_signed(input source_t src);
    is_signed = (src == SRC_X_ACCEL) || (src == SRC_Y_ACCEL) ||
                (src == SRC_X_TILT) || (src == SRC_Y_TILT);
  endfunction

  // widen to 15 bits in the output's format
  function automatic logic signed [14:0] widen(input datum_t x, input logic sgn);
    widen = $signed({sgn & x[LIM_DATA_MSB], x});
  endfunction

  // threshold test, direction from bit 15
  function automatic logic exceeds(input datum_t x, input logic [15:0] lim, input logic sgn);
    logic signed [14:0] xe;
    logic signed [14:0] le;
    xe = widen(x, sgn);
    le = widen(lim[LIM_DATA_MSB:0], sgn);
    exceeds = lim[LIM_ABOVE_BIT] ? (xe > le) : (xe < le);
  endfunction

  // one sample step of one alarm
  function automatic alarm_t alarm_step(input alarm_t a, input datum_t x, input logic [15:0] lim,
                                        input logic [15:0] smp, input logic slope, input logic sgn);
    alarm_t r;
    logic [7:0] n1;
    logic signed [14:0] dx;
    logic signed [23:0] dxw;
    logic signed [23:0] bound;
    r = a;
    n1 = (smp[SMP_COUNT_MSB:0] == 8'h00) ? 8'h01 : smp[SMP_COUNT_MSB:0];
    dx = widen(x, sgn) - widen(a.ref_val, sgn);
    dxw = $signed({{9{dx[14]}}, dx});
    // compare change against limit times count, no divider
    bound = $signed({{10{lim[LIM_DATA_MSB]}}, lim[LIM_DATA_MSB:0]}) * $signed({16'h0000, n1});
    if (!slope) begin
      r.active = exceeds(x, lim, sgn);
    end else if (!a.primed) begin
      // first sample only sets the reference
      r.ref_val = x;
      r.count = 8'h00;
      r.primed = 1'b1;
    end else if (({1'b0, a.count} + 9'h001) >= {1'b0, n1}) begin
      r.active = lim[LIM_ABOVE_BIT] ? (dxw > bound) : (dxw < bound);
      r.ref_val = x;
      r.count = 8'h00;
    end else begin
      r.count = a.count + 8'h01;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // state and wiring
  // ------------------------------------------------------------
  monitor_state_t s_reg; // all state of the monitor
  monitor_state_t s_next; // next value
  word_t req_word; // decoded register word
  logic ctl_wr; // control write taken this cycle
  logic nv_wr_en; // store write strobe
  logic [1:0] nv_wr_idx; // store word written
  logic [15:0] nv_rdata; // store read data
  datum_t [1:0] watched; // raw value seen by each alarm
  logic any_alarm; // either alarm active
  logic pin_level; // alarm pin level after polarity

  assign req_word = decode(reg_req.addr);
  assign reg_ready = (s_reg.state == ST_RUN);
  assign ctl_wr = reg_ready & reg_req.wr & (req_word == W_CONTROL);
  assign nv_wr_en = reg_ready & reg_req.wr & (req_word != W_CONTROL) & (req_word != W_NONE);
  assign nv_wr_idx = req_word[1:0];
  assign watched[0] = pick(samples_in, ctl_src(s_reg.control, 1'b0));
  assign watched[1] = pick(samples_in, ctl_src(s_reg.control, 1'b1));
  assign any_alarm = s_reg.al[0].active | s_reg.al[1].active;
  assign pin_level = s_reg.control[CTL_PIN_POL_BIT] ? any_alarm : ~any_alarm;

  // ------------------------------------------------------------
  // nonvolatile copy of limits and counts
  // ------------------------------------------------------------
  nv_word_store nv_word_store_inst (
    .core_clk(core_clk),
    .erase(nv_erase),
    .wr_en(nv_wr_en),
    .wr_idx(nv_wr_idx),
    .wr_data(reg_req.wdata & (req_word[1] ? SAMPLES_MASK : LIMIT_MASK)),
    .rd_idx(s_reg.idx[1:0]),
    .rd_data(nv_rdata)
  );

  // ------------------------------------------------------------
  // restore, register access, alarm evaluation, pins
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] w;
    logic own;
    s_next = s_reg;
    w = s_reg.idx - 3'h1;
    own = 1'b0;
    s_next.rsp.ack = 1'b0;
    case (s_reg.state)
      ST_FETCH: begin
        // copy stored words back after reset, one per cycle
        if (s_reg.idx != 3'h0) begin
          if (w[1]) begin
            s_next.samples[w[0]] = nv_rdata;
          end else begin
            s_next.limit[w[0]] = nv_rdata;
          end
        end
        if (s_reg.idx == FETCH_LAST) begin
          s_next.state = ST_RUN;
          s_next.idx = 3'h0;
        end else begin
          s_next.idx = s_reg.idx + 3'h1;
        end
      end
      ST_RUN: begin
        // register writes
        if (reg_req.wr) begin
          s_next.rsp.ack = 1'b1;
          case (req_word)
            W_LIMIT1, W_LIMIT2: begin
              s_next.limit[req_word[0]] = reg_req.wdata & LIMIT_MASK;
            end
            W_SAMPLES1, W_SAMPLES2: begin
              s_next.samples[req_word[0]] = reg_req.wdata & SAMPLES_MASK;
            end
            W_CONTROL: begin
              s_next.control = reg_req.wdata & CONTROL_MASK;
            end
            default: begin
            end
          endcase
        end else if (reg_req.rd) begin
          // registered read, unmapped reads zero
          s_next.rsp.ack = 1'b1;
          case (req_word)
            W_LIMIT1, W_LIMIT2: s_next.rsp.rdata = s_reg.limit[req_word[0]];
            W_SAMPLES1, W_SAMPLES2: s_next.rsp.rdata = s_reg.samples[req_word[0]];
            W_CONTROL: s_next.rsp.rdata = s_reg.control;
            default: s_next.rsp.rdata = 16'h0000;
          endcase
        end
        // each alarm on its own settings
        for (int k = 0; k < 2; k++) begin
          if (ctl_wr) begin
            // new settings restart the slope window
            s_next.al[k].primed = 1'b0;
            s_next.al[k].count = 8'h00;
          end else if (ctl_src(s_reg.control, k[0]) == SRC_OFF) begin
            s_next.al[k] = '0;
          end else if (sample_strobe) begin
            s_next.al[k] = alarm_step(s_reg.al[k], watched[k], s_reg.limit[k], s_reg.samples[k],
                                      ctl_slope(s_reg.control, k[0]),
                                      is_signed(ctl_src(s_reg.control, k[0])));
          end
          if (nv_wr_en && req_word[1] && (req_word[0] == k[0])) begin
            // a new count restarts that slope window, level kept
            s_next.al[k].primed = 1'b0;
            s_next.al[k].count = 8'h00;
          end
        end
      end
      default: begin
        s_next.state = ST_FETCH;
        s_next.idx = 3'h0;
      end
    endcase
    // pin owners: misc first, alarm next, gpio last
    for (int j = 0; j < 2; j++) begin
      own = s_reg.control[CTL_PIN_EN_BIT] & (s_reg.control[CTL_PIN_SEL_BIT] == j[0]);
      if (misc_claim[j]) begin
        s_next.pins.out[j] = misc_drive[j];
        s_next.pins.oe[j] = 1'b1;
      end else if (own) begin
        s_next.pins.out[j] = pin_level;
        s_next.pins.oe[j] = 1'b1;
      end else begin
        s_next.pins.out[j] = gpio_out[j];
        s_next.pins.oe[j] = gpio_oe[j];
      end
    end
  end

  // state register with defaults
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.state <= ST_FETCH;
      s_reg.limit <= {2{LIMIT_RESET}};
      s_reg.samples <= {2{SAMPLES_RESET}};
      s_reg.control <= CONTROL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign reg_rsp = s_reg.rsp;
  assign io_line_zero_out = s_reg.pins.out[0];
  assign io_line_zero_oe = s_reg.pins.oe[0];
  assign io_line_one_out = s_reg.pins.out[1];
  assign io_line_one_oe = s_reg.pins.oe[1];
  assign alarm1_active = s_reg.al[0].active;
  assign alarm2_active = s_reg.al[1].active;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // disabled source keeps alarm quiet
  property p_src_off;
    (reg_ready && !ctl_wr && ctl_src(s_reg.control, 1'b0) == SRC_OFF) |=> !s_reg.al[0].active;
  endproperty
  a_src_off: assert property (p_src_off) else $error("alarm1 active while disabled");

  // threshold above limit on unsigned supply
  property p_thr_above;
    (reg_ready && sample_strobe && !ctl_wr && ctl_src(s_reg.control, 1'b0) == SRC_SUPPLY &&
     !s_reg.control[CTL_SLOPE1_BIT] && s_reg.limit[0][LIM_ABOVE_BIT] &&
     (watched[0] > s_reg.limit[0][LIM_DATA_MSB:0])) |=> s_reg.al[0].active;
  endproperty
  a_thr_above: assert property (p_thr_above) else $error("threshold alarm missed");

  // alarm 2 changes only on a sample update or control write while its source is on
  property p_hold;
    (reg_ready && !sample_strobe && !ctl_wr && ctl_src(s_reg.control, 1'b1) != SRC_OFF)
      |=> $stable(s_reg.al[1].active);
  endproperty
  a_hold: assert property (p_hold) else $error("alarm2 changed without sample");

  // alarm-owned line follows either alarm
  property p_pin_or;
    (s_reg.control[CTL_PIN_EN_BIT] && !s_reg.control[CTL_PIN_SEL_BIT] && !misc_claim[0])
      |=> (io_line_zero_oe && io_line_zero_out == ($past(s_reg.control[CTL_PIN_POL_BIT]) ?
           $past(any_alarm) : !$past(any_alarm)));
  endproperty
  a_pin_or: assert property (p_pin_or) else $error("alarm pin level wrong");

  // pin drops with no alarm, active high
  property p_no_latch;
    (s_reg.control[2:0] == 3'h7 && !misc_claim[1] && !any_alarm) |=> !io_line_one_out;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("alarm pin latched");

  // misc claim takes the line
  property p_misc_wins;
    misc_claim[0] |=> (io_line_zero_oe && io_line_zero_out == $past(misc_drive[0]));
  endproperty
  a_misc_wins: assert property (p_misc_wins) else $error("misc claim lost line");

  // gpio gets the line only when nobody else claims it
  property p_gpio_last;
    (!misc_claim[1] && !(s_reg.control[CTL_PIN_EN_BIT] && s_reg.control[CTL_PIN_SEL_BIT]))
      |=> (io_line_one_oe == $past(gpio_oe[1]) && io_line_one_out == $past(gpio_out[1]));
  endproperty
  a_gpio_last: assert property (p_gpio_last) else $error("gpio ownership wrong");

  // limit write lands masked, bit 14 clear
  property p_limit_write;
    (reg_ready && reg_req.wr && req_word == W_LIMIT2)
      |=> (reg_rsp.ack && !s_reg.limit[1][14] && s_reg.limit[1] == ($past(reg_req.wdata) & LIMIT_MASK));
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit readback wrong");

  // slope window count stays below sample count
  property p_slope_count;
    (ctl_slope(s_reg.control, 1'b0) && s_reg.al[0].primed && s_reg.samples[0][7:0] > 8'h01)
      |-> (s_reg.al[0].count < s_reg.samples[0][7:0]);
  endproperty
  a_slope_count: assert property (p_slope_count) else $error("slope window overrun");

  // restore finishes in fixed time after reset
  property p_restore;
    $fell(rst) |-> ##5 reg_ready;
  endproperty
  a_restore: assert property (p_restore) else $error("restore too slow");

  c_alarm1: cover property (s_reg.al[0].active && !s_reg.control[CTL_SLOPE1_BIT]);
  c_slope2: cover property (s_reg.al[1].active && s_reg.control[CTL_SLOPE2_BIT]);
  c_pin: cover property (io_line_one_oe && s_reg.control[CTL_PIN_EN_BIT] && any_alarm);
  c_both: cover property (s_reg.al[0].active && s_reg.al[1].active);

endmodule // dual_alarm_monitor
`default_nettype wire

/* host_side_model.sv */
// host side of the alarm pins: resolves each io line as the host sees it
`timescale 1ns/100ps
`default_nettype none
module host_side_model (
  input wire logic core_clk,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] line_level
);
  // ------------------------------------------------------------
  // undriven line model
  // ------------------------------------------------------------
  logic float_reg = 1'b0; // toggles every cycle so a floating line never looks stable
  // pattern source for released lines
  always_ff @(posedge core_clk) begin
    float_reg <= ~float_reg;
  end
  // driven lines show the driver, released ones the pattern
  assign line_level[0] = pin_oe[0] ? pin_out[0] : float_reg;
  assign line_level[1] = pin_oe[1] ? pin_out[1] : float_reg;
endmodule // host_side_model
`default_nettype wire

/* test_dual_alarm_monitor.sv */
// self-checking bench for the dual alarm monitor
`timescale 1ns/100ps
`default_nettype none
module test_dual_alarm_monitor;
  import alarm_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0; // 100 MHz clock
  logic rst = 1'b1; // sync reset
  logic nv_erase = 1'b1; // first power-up erase
  logic sample_strobe = 1'b0; // sample update pulse
  sample_set_t samples_in = '0; // raw outputs
  reg_req_t reg_req = '0; // register request
  logic reg_ready; // requests taken
  reg_rsp_t reg_rsp; // register answer
  logic [1:0] misc_claim = 2'b00; // misc ownership
  logic [1:0] misc_drive = 2'b00; // misc level
  logic [1:0] gpio_out = 2'b01; // gpio level
  logic [1:0] gpio_oe = 2'b11; // gpio enable
  logic io0_out, io0_oe, io1_out, io1_oe; // pin drivers
  logic alarm1_active, alarm2_active; // alarm flags
  logic [1:0] line_level; // host view of pins
  int fails = 0; // mismatches
  int checks = 0; // comparisons
  // clock
  always #5 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  dual_alarm_monitor dual_alarm_monitor_inst (.core_clk(core_clk), .rst(rst), .nv_erase(nv_erase),
    .sample_strobe(sample_strobe), .samples_in(samples_in), .reg_req(reg_req), .reg_ready(reg_ready),
    .reg_rsp(reg_rsp), .misc_claim(misc_claim), .misc_drive(misc_drive), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .io_line_zero_out(io0_out), .io_line_zero_oe(io0_oe), .io_line_one_out(io1_out),
    .io_line_one_oe(io1_oe), .alarm1_active(alarm1_active), .alarm2_active(alarm2_active));
  host_side_model host_side_model_inst (.core_clk(core_clk), .pin_out({io1_out, io0_out}),
    .pin_oe({io1_oe, io0_oe}), .line_level(line_level));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // compare and count
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // wait for restore to finish, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    while (reg_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check("reg_ready", 16'h0001, {15'h0000, reg_ready});
  endtask
  // one register access, held until the taking edge
  task automatic reg_cycle(input logic wr, input logic [5:0] addr, input logic [15:0] wdata);
    @(negedge core_clk);
    reg_req = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
    @(negedge core_clk);
    reg_req = '0;
    check("ack", 16'h0001, {15'h0000, reg_rsp.ack});
  endtask
  // write a register
  task automatic reg_wr(input logic [5:0] addr, input logic [15:0] data);
    reg_cycle(1'b1, addr, data);
  endtask
  // read a register and compare
  task automatic reg_rd(input logic [5:0] addr, input logic [15:0] exp);
    reg_cycle(1'b0, addr, 16'h0000);
    check($sformatf("rdata at %h", addr), exp, reg_rsp.rdata);
  endtask
  // one sample update, alarms checked after one edge, pins settle one more
  task automatic fire(input sample_set_t s, input logic a1, input logic a2);
    @(negedge core_clk);
    sample_strobe = 1'b1;
    samples_in = s;
    @(negedge core_clk);
    sample_strobe = 1'b0;
    check("alarm1_active", {15'h0000, a1}, {15'h0000, alarm1_active});
    check("alarm2_active", {15'h0000, a2}, {15'h0000, alarm2_active});
    @(negedge core_clk);
  endtask
  // reset sequence, 6 cycles
  task automatic do_reset(input logic erase);
    rst = 1'b1;
    nv_erase = erase;
    repeat (6) @(negedge core_clk);
    nv_erase = 1'b0;
    rst = 1'b0;
    wait_ready();
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // register defaults, unmapped read, gpio owns pins with alarm off
  task automatic test_defaults();
    reg_rd(ADDR_LIMIT1, 16'h0000);
    reg_rd(ADDR_LIMIT2, 16'h0000);
    reg_rd(ADDR_SAMPLES1, 16'h0000);
    reg_rd(ADDR_SAMPLES2, 16'h0000);
    reg_rd(ADDR_CONTROL, 16'h0000);
    reg_rd(6'h30, 16'h0000);
    check("gpio lines", 16'h0001, {14'h0000, line_level});
    $display("test_defaults done");
  endtask
  // writable bits of limit1, samples1 and control
  task automatic test_masks();
    reg_wr(ADDR_LIMIT1, 16'hFFFF);
    reg_rd(ADDR_LIMIT1, 16'hBFFF);
    reg_wr(ADDR_SAMPLES1, 16'hFFFF);
    reg_rd(ADDR_SAMPLES1, 16'h00FF);
    reg_wr(ADDR_CONTROL, 16'hFFFF);
    reg_rd(ADDR_CONTROL, 16'hFF07);
    reg_wr(ADDR_CONTROL, 16'h0000);
    $display("test_masks done");
  endtask
  // limits survive reset, control does not
  task automatic test_keep();
    reg_wr(ADDR_LIMIT2, 16'h8123);
    reg_wr(ADDR_SAMPLES2, 16'h0042);
    reg_wr(ADDR_CONTROL, 16'h1100);
    do_reset(1'b0);
    reg_rd(ADDR_LIMIT2, 16'h8123);
    reg_rd(ADDR_SAMPLES2, 16'h0042);
    reg_rd(ADDR_CONTROL, 16'h0000);
    $display("test_keep done");
  endtask
  // unsigned threshold above and below, active-high pin on line one
  task automatic test_threshold();
    sample_set_t s;
    s = '0;
    reg_wr(ADDR_LIMIT1, 16'h8064);
    reg_wr(ADDR_CONTROL, 16'h0107);
    s.supply = 14'd200;
    fire(s, 1'b1, 1'b0);
    check("line one high", 16'h0001, {15'h0000, line_level[1]});
    s.supply = 14'd50;
    fire(s, 1'b0, 1'b0);
    check("line one low", 16'h0000, {15'h0000, line_level[1]});
    reg_wr(ADDR_LIMIT1, 16'h0064);
    fire(s, 1'b1, 1'b0);
    $display("test_threshold done");
  endtask
  // signed below on alarm 2, active-low line one, misc override, source off
  task automatic test_signed();
    sample_set_t s;
    s = '0;
    reg_wr(ADDR_LIMIT2, 16'h3FFB);
    reg_wr(ADDR_CONTROL, 16'h2105);
    s.x_accel = 14'h3FF6;
    s.supply = 14'd200;
    fire(s, 1'b0, 1'b1);
    check("line one active low", 16'h0000, {15'h0000, line_level[1]});
    check("host sees flag", 16'h0001, {15'h0000, alarm2_active});
    misc_claim = 2'b11;
    misc_drive = 2'b10;
    repeat (2) @(negedge core_clk);
    check("misc wins", 16'h0001, {15'h0000, line_level[1]});
    check("misc wins zero", 16'h0000, {15'h0000, line_level[0]});
    misc_claim = 2'b00;
    reg_wr(ADDR_CONTROL, 16'h0005);
    @(negedge core_clk);
    check("source off", 16'h0000, {15'h0000, alarm2_active});
    $display("test_signed done");
  endtask
  // slope over two samples against limit of ten per sample
  task automatic test_slope();
    sample_set_t s;
    s = '0;
    reg_wr(ADDR_SAMPLES1, 16'h0002);
    reg_wr(ADDR_LIMIT1, 16'h800A);
    reg_wr(ADDR_CONTROL, 16'h0906);
    s.supply = 14'd100;
    fire(s, 1'b0, 1'b0);
    check("slope pin idle", 16'h0000, {15'h0000, line_level[0]});
    s.supply = 14'd110;
    fire(s, 1'b0, 1'b0);
    s.supply = 14'd130;
    fire(s, 1'b1, 1'b0);
    check("slope pin", 16'h0001, {15'h0000, line_level[0]});
    $display("test_slope done");
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    do_reset(1'b1);
    test_defaults();
    test_masks();
    test_keep();
    test_threshold();
    test_signed();
    test_slope();
    summarize();
  end
  // cuts a hang short
  initial begin
    #50000;
    fails++;
    summarize();
  end
endmodule // test_dual_alarm_monitor
`default_nettype wire
